// File: shared/lpm_pkg.sv
package lpm_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses on the APB side)
   // ----------------------------------------------------------------
   localparam int         ADDR_W           = 8;
   localparam logic [7:0] OFS_SYS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_SYS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_WAKE_EN      = 8'h08;
   localparam logic [7:0] OFS_STATUS       = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CTRL     = 8'h10;
   localparam logic [7:0] OFS_IRQ_LATCH    = 8'h14;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SC1_STOP_BIT  = 7;
   localparam int SC1_RELEASE_METHOD_SELECT_BIT  = 6;
   localparam int SC1_RETURN_MODE_SELECT_BIT  = 5;
   localparam int SC1_OUTEN_BIT = 4;
   localparam int SC1_WUT_LSB   = 1;
   localparam int SC2_XEN_BIT   = 7;
   localparam int SC2_XTEN_BIT  = 6;
   localparam int SC2_SYSCK_BIT = 5;
   localparam int SC2_IDLE_BIT  = 4;
   localparam int IRQ_IMF_BIT   = 8;
   localparam int NUM_IRQ       = 8;
   localparam int KEY_W         = 4;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic       RST_RELEASE_METHOD_SELECT    = 1'b0;
   localparam logic       RST_RETURN_MODE_SELECT    = 1'b0;
   localparam logic       RST_OUTEN   = 1'b0;
   localparam logic [2:0] RST_WUT     = 3'h0;
   localparam logic       RST_XEN     = 1'b1;
   localparam logic       RST_XTEN    = 1'b0;
   localparam logic       RST_SYSCK   = 1'b0;
   localparam logic [3:0] RST_WAKE_EN = 4'h0;

   // ----------------------------------------------------------------
   // warm-up: count = (3 or 1) << exponent, in basic clock cycles
   // ----------------------------------------------------------------
   localparam int WU_CNT_W     = 18;
   localparam int FAST_EXP_HI  = 16;
   localparam int FAST_EXP_MID = 14;
   localparam int FAST_EXP_LO  = 10;
   localparam int SLOW_EXP_HI  = 13;
   localparam int SLOW_EXP_LO  = 6;

   typedef enum logic [3:0] {
      ST_RUN  = 4'b0001,
      ST_HALT = 4'b0010,
      ST_WARM = 4'b0100,
      ST_IDLE = 4'b1000
   } lpm_state_t;

endpackage

// File: verilog/warmup_divider.sv
`timescale 1ns/1ns
module warmup_divider
#(
   parameter int CNT_W = 18
)
(
   // clock and reset
   input  wire logic             i_clk_sys,
   input  wire logic             i_rst,
   input  wire logic             i_clear,
   // control
   input  wire logic             i_load,
   input  wire logic [CNT_W-1:0] i_count,
   // status
   output logic                  o_busy,
   output logic                  o_done
);

   logic [CNT_W-1:0] divider;
   logic [CNT_W-1:0] target;

   // the divider restarts from zero on every load, so the interval always
   // spans the full count of basic clock cycles
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         divider <= '0;
         target  <= '0;
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
      end
      else if (i_clear)
      begin
         divider <= '0;
         target  <= '0;
         o_busy  <= 1'b0;
         o_done  <= 1'b0;
      end
      else if (i_load)
      begin
         divider <= '0;
         target  <= i_count - CNT_W'(1);
         o_busy  <= 1'b1;
         o_done  <= 1'b0;
      end
      else if (o_busy)
      begin
         divider <= divider + CNT_W'(1);
         o_done  <= (divider == target);
         o_busy  <= (divider != target);
      end
      else
      begin
         o_done <= 1'b0;
      end
   end

endmodule // warmup_divider

// File: verilog/low_power_mode_wake_control.sv
// Our own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module low_power_mode_wake_control
   import lpm_pkg::*;
#(
   parameter int FAST_HI = lpm_pkg::FAST_EXP_HI,
   parameter int FAST_MID = lpm_pkg::FAST_EXP_MID,
   parameter int FAST_LO = lpm_pkg::FAST_EXP_LO,
   parameter int SLOW_HI = lpm_pkg::SLOW_EXP_HI,
   parameter int SLOW_LO = lpm_pkg::SLOW_EXP_LO
)
(
   // clock and reset
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [lpm_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]               pwdata,
   output logic [31:0]                    prdata,
   output logic                           pready,
   output logic                           pslverr,
   // wake and reset pins
   input  wire logic                      i_port2_bit0,
   input  wire logic [lpm_pkg::KEY_W-1:0] i_key_wake_inputs,
   input  wire logic                      i_reset_pin_n,
   // interrupt sources
   input  wire logic [lpm_pkg::NUM_IRQ-1:0] i_irq_req,
   input  wire logic                      i_wdt_irq,
   // core and clock control
   output logic                           o_core_halt,
   output logic                           o_wdt_halt,
   output logic                           o_osc_fast_en,
   output logic                           o_osc_slow_en,
   output logic                           o_clk_slow_sel,
   output logic                           o_prescaler_clr,
   output logic                           o_resume,
   output logic                           o_irq_service,
   output logic                           o_sys_reset,
   output logic                           o_ports_hiz
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   lpm_state_t           state;
   lpm_state_t           next_state;
   logic                 release_method_select;
   logic                 return_mode_select;
   logic                 outen;
   logic [2:0]           warmup_select;
   logic                 xen;
   logic                 xten;
   logic                 sysck;
   logic                 idle_bit;
   logic [KEY_W-1:0]     wake_input_enable_reg;
   logic                 master_irq_enable;
   logic [NUM_IRQ-1:0]   irq_enable_flag;
   logic [NUM_IRQ-1:0]   irq_latch;
   logic                 level_active;
   logic                 pin_prev;
   logic                 pin_rise;
   logic                 level_wake;
   logic                 irq_wake;
   logic                 wr_en;
   logic                 rd_en;
   logic                 addr_ok;
   logic                 stop_cmd;
   logic                 idle_cmd;
   logic                 dual_clock;
   logic                 wu_load;
   logic                 wu_busy;
   logic                 wu_done;
   logic [WU_CNT_W-1:0]  wu_count;
   logic [31:0]          next_rdata;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   assign wr_en    = psel && penable && pready && pwrite;
   assign rd_en    = psel && !penable && !pwrite;
   assign addr_ok  = (paddr == OFS_SYS_CTRL_ONE) || (paddr == OFS_SYS_CTRL_TWO) ||
                     (paddr == OFS_WAKE_EN) || (paddr == OFS_STATUS) ||
                     (paddr == OFS_IRQ_CTRL) || (paddr == OFS_IRQ_LATCH);
   assign stop_cmd = wr_en && (paddr == OFS_SYS_CTRL_ONE) && pwdata[SC1_STOP_BIT];
   assign idle_cmd = wr_en && (paddr == OFS_SYS_CTRL_TWO) && pwdata[SC2_IDLE_BIT];

   // no wait state: pready is already high in the first access cycle, data prepared in setup
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (rd_en)
         begin
            prdata <= next_rdata;
         end
      end
   end

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      unique case (paddr)
         OFS_SYS_CTRL_ONE:
         begin
            next_rdata[SC1_RELEASE_METHOD_SELECT_BIT]  = release_method_select;
            next_rdata[SC1_RETURN_MODE_SELECT_BIT]  = return_mode_select;
            next_rdata[SC1_OUTEN_BIT] = outen;
            next_rdata[SC1_WUT_LSB+:3] = warmup_select;
         end
         OFS_SYS_CTRL_TWO:
         begin
            next_rdata[SC2_XEN_BIT]   = xen;
            next_rdata[SC2_XTEN_BIT]  = xten;
            next_rdata[SC2_SYSCK_BIT] = sysck;
            next_rdata[SC2_IDLE_BIT]  = idle_bit;
         end
         OFS_WAKE_EN:   next_rdata[KEY_W-1:0] = wake_input_enable_reg;
         OFS_STATUS:    next_rdata[7:0] = {1'b0, pin_prev, level_active, wu_busy, state};
         OFS_IRQ_CTRL:  next_rdata[IRQ_IMF_BIT:0] = {master_irq_enable, irq_enable_flag};
         OFS_IRQ_LATCH: next_rdata[NUM_IRQ-1:0] = irq_latch;
         default:       next_rdata = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------------------------------
   // control registers (reset pin restores them like a power-on)
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         release_method_select <= RST_RELEASE_METHOD_SELECT;
         return_mode_select    <= RST_RETURN_MODE_SELECT;
         outen                 <= RST_OUTEN;
         warmup_select         <= RST_WUT;
         wake_input_enable_reg <= RST_WAKE_EN;
         master_irq_enable     <= 1'b0;
         irq_enable_flag       <= '0;
      end
      else if (!i_reset_pin_n)
      begin
         release_method_select <= RST_RELEASE_METHOD_SELECT;
         return_mode_select    <= RST_RETURN_MODE_SELECT;
         outen                 <= RST_OUTEN;
         warmup_select         <= RST_WUT;
         wake_input_enable_reg <= RST_WAKE_EN;
         master_irq_enable     <= 1'b0;
         irq_enable_flag       <= '0;
      end
      else if (wr_en)
      begin
         if (paddr == OFS_SYS_CTRL_ONE)
         begin
            release_method_select <= pwdata[SC1_RELEASE_METHOD_SELECT_BIT];
            return_mode_select    <= pwdata[SC1_RETURN_MODE_SELECT_BIT];
            outen                 <= pwdata[SC1_OUTEN_BIT];
            warmup_select         <= pwdata[SC1_WUT_LSB+:3];
         end
         if (paddr == OFS_WAKE_EN)
         begin
            wake_input_enable_reg <= pwdata[KEY_W-1:0];
         end
         if (paddr == OFS_IRQ_CTRL)
         begin
            master_irq_enable <= pwdata[IRQ_IMF_BIT];
            irq_enable_flag   <= pwdata[NUM_IRQ-1:0];
         end
      end
   end

   // oscillator and clock select bits; the wake sequence overwrites them
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         xen   <= RST_XEN;
         xten  <= RST_XTEN;
         sysck <= RST_SYSCK;
      end
      else if (!i_reset_pin_n)
      begin
         xen   <= RST_XEN;
         xten  <= RST_XTEN;
         sysck <= RST_SYSCK;
      end
      else if (wu_load)
      begin
         xen   <= !return_mode_select;
         xten  <= return_mode_select || dual_clock;
         sysck <= return_mode_select;
      end
      else if (wr_en && (paddr == OFS_SYS_CTRL_TWO))
      begin
         xen   <= pwdata[SC2_XEN_BIT];
         xten  <= pwdata[SC2_XTEN_BIT];
         sysck <= pwdata[SC2_SYSCK_BIT];
      end
   end

   // interrupt latches: write one to clear, a new request in the same cycle wins
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_latch <= '0;
      end
      else if (!i_reset_pin_n)
      begin
         irq_latch <= '0;
      end
      else if (wr_en && (paddr == OFS_IRQ_LATCH))
      begin
         irq_latch <= (irq_latch & ~pwdata[NUM_IRQ-1:0]) | i_irq_req;
      end
      else
      begin
         irq_latch <= irq_latch | i_irq_req;
      end
   end

   // ----------------------------------------------------------------
   // wake detection
   // ----------------------------------------------------------------
   assign pin_rise   = i_port2_bit0 && !pin_prev;
   assign level_wake = i_port2_bit0 ||
                       |(wake_input_enable_reg & ~i_key_wake_inputs);
   assign irq_wake   = |(irq_latch & irq_enable_flag);
   assign dual_clock = xten;

   // level release only becomes live after a rising edge on the wake pin;
   // going back to edge release is immediate
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         pin_prev     <= 1'b0;
         level_active <= RST_RELEASE_METHOD_SELECT;
      end
      else
      begin
         pin_prev     <= i_port2_bit0;
         level_active <= release_method_select && (level_active || pin_rise);
      end
   end

   // ----------------------------------------------------------------
   // warm-up count selection
   // ----------------------------------------------------------------
   always_comb
   begin
      int  exp_sel;
      logic triple;
      exp_sel = 0;
      triple  = 1'b0;
      // codes x01 and x11 ignore the top bit
      if (warmup_select[0])
      begin
         exp_sel = return_mode_select ? SLOW_LO : FAST_LO;
         triple  = !warmup_select[1];
      end
      else
      begin
         exp_sel = warmup_select[2] ? (return_mode_select ? SLOW_LO : FAST_MID)
                                    : (return_mode_select ? SLOW_HI : FAST_HI);
         triple  = !warmup_select[1];
      end
      wu_count = triple ? (WU_CNT_W'(3) << exp_sel) : (WU_CNT_W'(1) << exp_sel);
   end

   warmup_divider
   #(
      .CNT_W (WU_CNT_W)
   )
   u_warmup
   (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_clear   (!i_reset_pin_n),
      .i_load    (wu_load),
      .i_count   (wu_count),
      .o_busy    (wu_busy),
      .o_done    (wu_done)
   );

   // ----------------------------------------------------------------
   // mode sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      wu_load    = 1'b0;
      unique case (state)
         ST_RUN:
         begin
            if (stop_cmd)
            begin
               if (level_active && level_wake)
               begin
                  next_state = ST_WARM;
                  wu_load    = 1'b1;
               end
               else
               begin
                  next_state = ST_HALT;
               end
            end
            else if (idle_cmd && !i_wdt_irq)
            begin
               next_state = ST_IDLE;
            end
         end
         ST_HALT:
         begin
            if (level_active ? level_wake : pin_rise)
            begin
               next_state = ST_WARM;
               wu_load    = 1'b1;
            end
         end
         ST_WARM:
         begin
            // no path back to halt: wake inputs are ignored from here on
            if (wu_done)
            begin
               next_state = ST_RUN;
            end
         end
         ST_IDLE:
         begin
            if (irq_wake)
            begin
               next_state = ST_RUN;
            end
         end
         default: next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         state <= ST_RUN;
      end
      else if (!i_reset_pin_n)
      begin
         state <= ST_RUN;
      end
      else
      begin
         state <= next_state;
      end
   end

   // idle bit reads back one while the light idle mode lasts
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         idle_bit <= 1'b0;
      end
      else
      begin
         idle_bit <= (next_state == ST_IDLE) && i_reset_pin_n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_core_halt     <= 1'b0;
         o_wdt_halt      <= 1'b0;
         o_osc_fast_en   <= RST_XEN;
         o_osc_slow_en   <= RST_XTEN;
         o_clk_slow_sel  <= RST_SYSCK;
         o_prescaler_clr <= 1'b0;
         o_resume        <= 1'b0;
         o_irq_service   <= 1'b0;
         o_sys_reset     <= 1'b1;
         o_ports_hiz     <= 1'b0;
      end
      else
      begin
         // core only clock-gated, so memory, registers and pc+2 are retained
         o_core_halt     <= (next_state != ST_RUN) && i_reset_pin_n;
         o_wdt_halt      <= (next_state != ST_RUN) && i_reset_pin_n;
         o_osc_fast_en   <= (next_state != ST_HALT) && (wu_load ? !return_mode_select : xen);
         o_osc_slow_en   <= (next_state != ST_HALT) && (xten || (wu_load && return_mode_select));
         o_clk_slow_sel  <= sysck;
         o_prescaler_clr <= wu_load;
         o_resume        <= ((state == ST_WARM) && wu_done) ||
                            ((state == ST_IDLE) && irq_wake);
         o_irq_service   <= ((state == ST_IDLE) && irq_wake && master_irq_enable) ||
                            ((state == ST_RUN) && idle_cmd && i_wdt_irq);
         o_sys_reset     <= !i_reset_pin_n;
         o_ports_hiz     <= (next_state == ST_HALT) && !outen && i_reset_pin_n;
      end
   end

endmodule // low_power_mode_wake_control

// File: verif/lpm_monitor.sv
`timescale 1ns/1ns
module lpm_monitor
(
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   // watched ports
   input  wire logic i_reset_pin_n,
   input  wire logic o_core_halt,
   input  wire logic o_wdt_halt,
   input  wire logic o_osc_fast_en,
   input  wire logic o_osc_slow_en,
   input  wire logic o_clk_slow_sel,
   input  wire logic o_prescaler_clr,
   input  wire logic o_resume,
   input  wire logic o_sys_reset,
   input  wire logic o_ports_hiz
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   halt_pair_a: assert property (o_core_halt == o_wdt_halt)
      else $error("core and watchdog halt differ");
   resume_pulse_a: assert property (o_resume |=> !o_resume)
      else $error("resume longer than one cycle");
   clear_pulse_a: assert property (o_prescaler_clr |=> !o_prescaler_clr)
      else $error("prescaler clear longer than one cycle");
   clear_warm_a: assert property (o_prescaler_clr |-> o_core_halt &&
      (o_osc_fast_en || o_osc_slow_en)) else $error("clear outside warm-up");
   hiz_stopped_a: assert property (o_ports_hiz |->
      o_core_halt && !o_osc_fast_en && !o_osc_slow_en) else $error("hiz while running");
   pin_reset_a: assert property ($fell(i_reset_pin_n) |-> ##[1:2] o_sys_reset)
      else $error("reset pin not followed by reset");
   reset_mode_a: assert property (!i_reset_pin_n [*3] |-> o_sys_reset &&
      !o_core_halt && o_osc_fast_en && !o_osc_slow_en && !o_clk_slow_sel)
      else $error("reset does not restore fast single clock run");
   wake_resume_a: assert property ($fell(o_core_halt) && $past(i_reset_pin_n) &&
      $past(i_reset_pin_n, 2) |-> ##[0:2] o_resume) else $error("no resume after halt");
endmodule // lpm_monitor

// File: verif/wake_pin_model.sv
`timescale 1ns/1ns
module wake_pin_model
(
   input  wire logic                      i_clk_sys,
   output logic                           o_pin,
   output logic [lpm_pkg::KEY_W-1:0]      o_keys,
   output logic                           o_rst_n,
   output logic [lpm_pkg::NUM_IRQ-1:0]    o_irq,
   output logic                           o_wdt
);
   initial
   begin
      o_pin = 1'b0;
      o_keys = 4'hF;
      o_rst_n = 1'b1;
      o_irq = 8'h00;
      o_wdt = 1'b0;
   end
   task drive(input logic p, input logic [3:0] k);
      @(posedge i_clk_sys);
      o_pin <= p;
      o_keys <= k;
   endtask
   // peripherals raise a request for a single cycle
   task pulse_irq(input int b);
      @(posedge i_clk_sys);
      o_irq <= 8'h01 << b;
      @(posedge i_clk_sys);
      o_irq <= 8'h00;
   endtask
   task reset_pulse;
      @(posedge i_clk_sys);
      o_rst_n <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      o_rst_n <= 1'b1;
   endtask
   task set_wdt(input logic v);
      @(posedge i_clk_sys);
      o_wdt <= v;
   endtask
endmodule // wake_pin_model

// File: verif/testbench.sv
`timescale 1ns/1ns
module testbench
   import lpm_pkg::*;
   ;
   // ----
   // stimulus and observation
   // ----
   localparam int         FH = 6, FM = 5, FL = 4;
   localparam logic [2:0] WCODE [6] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1, 3'h3};
   localparam int         WCNT [6] = '{3<<FH, 1<<FH, 3<<FM, 1<<FM, 3<<FL, 1<<FL};
   // return_mode_select, xten, fast osc, slow osc
   localparam logic [3:0] OSC [3] = '{4'h2, 4'h7, 4'hD};
   logic        i_clk_sys, i_rst, psel, penable, pwrite, pready, pslverr, last_err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic        o_core_halt, o_wdt_halt, o_osc_fast_en, o_osc_slow_en, o_clk_slow_sel;
   logic        o_prescaler_clr, o_resume, o_irq_service, o_sys_reset, o_ports_hiz;
   wire logic   pin, rst_n, wdt;
   wire logic [3:0] keys;
   wire logic [7:0] irq;
   int          err_count, samples_checked, svc_n, pcl_n;

   low_power_mode_wake_control #(.FAST_HI(FH), .FAST_MID(FM), .FAST_LO(FL),
      .SLOW_LO(3)) DUT (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_port2_bit0(pin),
      .i_key_wake_inputs(keys), .i_reset_pin_n(rst_n), .i_irq_req(irq), .i_wdt_irq(wdt),
      .o_core_halt(o_core_halt), .o_wdt_halt(o_wdt_halt), .o_osc_fast_en(o_osc_fast_en),
      .o_osc_slow_en(o_osc_slow_en), .o_clk_slow_sel(o_clk_slow_sel),
      .o_prescaler_clr(o_prescaler_clr), .o_resume(o_resume),
      .o_irq_service(o_irq_service), .o_sys_reset(o_sys_reset), .o_ports_hiz(o_ports_hiz));
   wake_pin_model pins (.i_clk_sys(i_clk_sys), .o_pin(pin), .o_keys(keys), .o_rst_n(rst_n),
      .o_irq(irq), .o_wdt(wdt));

   initial
   begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   // pulses are counted mid-cycle, where they are settled
   always @(negedge i_clk_sys)
   begin
      if (o_irq_service === 1'b1) svc_n++;
      if (o_prescaler_clr === 1'b1) pcl_n++;
   end

   // ----
   // shared tasks
   // ----
   task summarize;
      if (err_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task hang;
      err_count++;
      summarize;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge i_clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge i_clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) hang;
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(nm, r & m, e);
   endtask
   // waits for the next resume (sel 0) or prescaler clear (sel 1) pulse
   task wait_ev(input int sel, output int n);
      n = 0;
      do
      begin
         @(negedge i_clk_sys);
         n++;
      end while ((sel == 0 ? o_resume : o_prescaler_clr) !== 1'b1 && n < 3000);
      if (n >= 3000) hang;
   endtask

   // ----
   // scenarios
   // ----
   task t_regs;
      rdc("sys2", OFS_SYS_CTRL_TWO, 32'hF0, 32'h80);
      rdc("status", OFS_STATUS, 32'hF, 32'h1);
      rdc("unmapped", 8'h18, 32'hFFFFFFFF, 32'h0);
      chk("slverr", {31'h0, last_err}, 32'h1);
   endtask
   task t_warm;
      int d [6];
      int s;
      s = pcl_n;
      for (int i = 0; i < 6; i++)
      begin
         pins.drive(1'b1, 4'hF);
         wr(OFS_SYS_CTRL_ONE, 32'h80 | (32'(WCODE[i]) << 1));
         repeat (4) @(posedge i_clk_sys);
         rdc("edge halt", OFS_STATUS, 32'hF, 32'h2);
         pins.drive(1'b0, 4'hF);
         pins.drive(1'b1, 4'hF);
         wait_ev(0, d[i]);
      end
      for (int i = 0; i < 5; i++)
         chk("warm-up", 32'(d[i] - d[5]), 32'(WCNT[i] - WCNT[5]));
      chk("clears", 32'(pcl_n - s), 32'd6);
   endtask
   task t_osc;
      int n;
      logic [3:0] e;
      for (int i = 0; i < 3; i++)
      begin
         e = OSC[i];
         wr(OFS_SYS_CTRL_TWO, 32'h80 | (32'(e[2]) << 6));
         pins.drive(1'b0, 4'hF);
         wr(OFS_SYS_CTRL_ONE, 32'h86 | (32'(e[3]) << 5));
         pins.drive(1'b1, 4'hF);
         wait_ev(1, n);
         chk("osc", {30'h0, o_osc_fast_en, o_osc_slow_en}, {30'h0, e[1:0]});
         wait_ev(0, n);
         chk("slow sel", {31'h0, o_clk_slow_sel}, {31'h0, e[3]});
      end
      wr(OFS_SYS_CTRL_TWO, 32'h80);
   endtask
   task t_level;
      int n;
      pins.drive(1'b0, 4'hF);
      wr(OFS_WAKE_EN, 32'hF);
      wr(OFS_SYS_CTRL_ONE, 32'h40);
      wr(OFS_SYS_CTRL_ONE, 32'hC0);
      pins.drive(1'b0, 4'hE);
      repeat (4) @(posedge i_clk_sys);
      rdc("not yet level", OFS_STATUS, 32'hF, 32'h2);
      pins.drive(1'b1, 4'hE);
      wait_ev(0, n);
      pins.drive(1'b0, 4'hF);
      wr(OFS_SYS_CTRL_ONE, 32'hC0);
      rdc("level halt", OFS_STATUS, 32'hF, 32'h2);
      pins.drive(1'b0, 4'hE);
      repeat (3) @(posedge i_clk_sys);
      pins.drive(1'b0, 4'hF);
      repeat (3) @(posedge i_clk_sys);
      rdc("key wake", OFS_STATUS, 32'hF, 32'h4);
      wait_ev(0, n);
      pins.drive(1'b1, 4'hF);
      wr(OFS_SYS_CTRL_ONE, 32'hC0);
      rdc("no halt", OFS_STATUS, 32'hF, 32'h4);
      wait_ev(0, n);
      pins.drive(1'b0, 4'hF);
   endtask
   task t_reset;
      wr(OFS_SYS_CTRL_ONE, 32'h80);
      rdc("halt", OFS_STATUS, 32'hF, 32'h2);
      pins.reset_pulse;
      repeat (2) @(posedge i_clk_sys);
      rdc("after reset", OFS_STATUS, 32'hF, 32'h1);
      rdc("sys1 reset", OFS_SYS_CTRL_ONE, 32'h7E, 32'h0);
      rdc("sys2 reset", OFS_SYS_CTRL_TWO, 32'hF0, 32'h80);
   endtask
   task t_idle;
      int s, n;
      wr(OFS_IRQ_CTRL, 32'h004);
      wr(OFS_SYS_CTRL_TWO, 32'h90);
      rdc("idle", OFS_STATUS, 32'hF, 32'h8);
      rdc("idle bit", OFS_SYS_CTRL_TWO, 32'hF0, 32'h90);
      @(negedge i_clk_sys);
      chk("halts", {30'h0, o_core_halt, o_wdt_halt}, 32'h3);
      s = svc_n;
      pins.pulse_irq(2);
      wait_ev(0, n);
      repeat (3) @(negedge i_clk_sys);
      chk("no vector", 32'(svc_n - s), 32'h0);
      rdc("idle clear", OFS_SYS_CTRL_TWO, 32'hF0, 32'h80);
      rdc("latch", OFS_IRQ_LATCH, 32'hFF, 32'h04);
      wr(OFS_IRQ_LATCH, 32'h04);
      rdc("latch clr", OFS_IRQ_LATCH, 32'hFF, 32'h00);
      wr(OFS_SYS_CTRL_TWO, 32'hE0);
      wr(OFS_IRQ_CTRL, 32'h104);
      wr(OFS_SYS_CTRL_TWO, 32'hF0);
      s = svc_n;
      pins.pulse_irq(2);
      wait_ev(0, n);
      repeat (3) @(negedge i_clk_sys);
      chk("vector", 32'(svc_n - s), 32'h1);
      chk("slow kept", {31'h0, o_clk_slow_sel}, 32'h1);
      wr(OFS_IRQ_LATCH, 32'h04);
      wr(OFS_SYS_CTRL_TWO, 32'h80);
      pins.set_wdt(1'b1);
      s = svc_n;
      wr(OFS_SYS_CTRL_TWO, 32'h90);
      repeat (3) @(posedge i_clk_sys);
      rdc("wdt blocks", OFS_STATUS, 32'hF, 32'h1);
      chk("wdt vector", 32'(svc_n - s), 32'h1);
      pins.set_wdt(1'b0);
   endtask

   initial
   begin
      i_rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      t_regs;
      t_warm;
      t_osc;
      t_level;
      t_reset;
      t_idle;
      summarize;
   end
endmodule // testbench

bind low_power_mode_wake_control lpm_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
   .i_reset_pin_n(i_reset_pin_n), .o_core_halt(o_core_halt), .o_wdt_halt(o_wdt_halt),
   .o_osc_fast_en(o_osc_fast_en), .o_osc_slow_en(o_osc_slow_en),
   .o_clk_slow_sel(o_clk_slow_sel), .o_prescaler_clr(o_prescaler_clr),
   .o_resume(o_resume), .o_sys_reset(o_sys_reset), .o_ports_hiz(o_ports_hiz));
